/* File: hw/dacref_defines.svh */
// Functional notes
// - converter runs only while the enable bit 7 of the control register is set.
// - five-bit level code selects one of 32 ladder taps.
// - pin a route enable connects ladder voltage to pin a, clear disconnects.
// - top source 00 supply, 01 external positive, 10 fixed buffer, 11 reserved.
// - bottom source bit set selects external negative pin, clear selects ground.
// - a routed pin loses digital driver, weak pull-up and input threshold detector.
// - digital read of a routed pin always returns zero.
// - clearing enable leaves pins with route enables set still connected.
// - waking from sleep leaves the control register unchanged.
// - reset disables converter, releases both pins, clears level code.
// - unimplemented bits ignore writes and read as zero.
`ifndef DACREF_DEFINES_SVH
`define DACREF_DEFINES_SVH

// register byte offsets
`define DACREF_CTRL_OFS   4'h0
`define DACREF_LEVEL_OFS  4'h4

// control register fields
`define DACREF_ON_BIT     7
`define DACREF_PINA_BIT   5
`define DACREF_PINB_BIT   4
`define DACREF_TOP_MSB    3
`define DACREF_TOP_LSB    2
`define DACREF_BOTTOM_BIT 0
`define DACREF_CTRL_MASK  8'hbd

// level register fields
`define DACREF_CODE_MSB   4
`define DACREF_LEVEL_MASK 8'h1f

// reset values
`define DACREF_CTRL_RST   8'h00
`define DACREF_LEVEL_RST  8'h00

// top source encodings
`define DACREF_TOP_SUPPLY 2'h0
`define DACREF_TOP_EXTPOS 2'h1
`define DACREF_TOP_FIXED  2'h2
`define DACREF_TOP_RSVD   2'h3

// bus wait states before the answer
`define DACREF_WAIT_CYCLES 1

`endif

/* File: hw/dacref_pkg.sv */
`default_nettype none
package dacref_pkg;

    // avalon request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } dacref_avs_req_t;

    // controls toward the ladder and its switches
    typedef struct packed {
        logic        ladder_on;
        logic [31:0] tap_sel;
        logic [2:0]  top_sw;     // supply, ext positive, fixed buffer
        logic [1:0]  bottom_sw;  // ground, ext negative
        logic        pin_a_sw;
        logic        pin_b_sw;
    } dacref_analog_t;

    // whole state of the top module
    typedef struct packed {
        logic [7:0]     ctrl;
        logic [7:0]     level;
        logic [31:0]    rdata;
        dacref_analog_t ana;
    } dacref_state_t;

endpackage
`default_nettype wire

/* File: hw/dacref_avs_handshake.sv */
`default_nettype none
module dacref_avs_handshake (
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    input  wire logic i_read,
    input  wire logic i_write,
    output logic      o_waitrequest,
    output logic      o_accept
);
    typedef struct packed {
        logic ack;
    } dacref_hs_state_t;

    dacref_hs_state_t st;
    dacref_hs_state_t next_st;
    logic             req;

    // one wait state, then the answer cycle
    always_comb begin
        req        = i_read | i_write;
        next_st    = st;
        next_st.ack = req & ~st.ack;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_waitrequest = req & ~st.ack;
    assign o_accept      = req & st.ack;
endmodule // dacref_avs_handshake
`default_nettype wire

/* File: hw/dacref_pin_route.sv */
`default_nettype none
module dacref_pin_route (
    input  wire logic i_route_en,
    input  wire logic i_pin_in,
    input  wire logic i_drv_req,
    input  wire logic i_pullup_req,
    output logic      o_drv_en,
    output logic      o_pullup_en,
    output logic      o_inbuf_en,
    output logic      o_read
);
    // analog routing overrides the digital pin functions
    assign o_drv_en    = i_drv_req & ~i_route_en;
    assign o_pullup_en = i_pullup_req & ~i_route_en;
    assign o_inbuf_en  = ~i_route_en;
    assign o_read      = i_pin_in & ~i_route_en;
endmodule // dacref_pin_route
`default_nettype wire

/* File: hw/dacref_top.sv */
`include "dacref_defines.svh"
`default_nettype none
module dacref_top (
    input  wire logic                       i_mclk,
    input  wire logic                       i_rstn,
    // register bus
    input  wire dacref_pkg::dacref_avs_req_t i_avs_req,
    output logic                            o_avs_waitrequest,
    output logic [31:0]                     o_avs_readdata,
    // analog controls
    output dacref_pkg::dacref_analog_t      o_analog,
    // pin a
    input  wire logic                       i_pin_a_in,
    input  wire logic                       i_pin_a_drv_req,
    input  wire logic                       i_pin_a_pullup_req,
    output logic                            o_pin_a_drv_en,
    output logic                            o_pin_a_pullup_en,
    output logic                            o_pin_a_inbuf_en,
    output logic                            o_pin_a_read,
    // pin b
    input  wire logic                       i_pin_b_in,
    input  wire logic                       i_pin_b_drv_req,
    input  wire logic                       i_pin_b_pullup_req,
    output logic                            o_pin_b_drv_en,
    output logic                            o_pin_b_pullup_en,
    output logic                            o_pin_b_inbuf_en,
    output logic                            o_pin_b_read
);
    import dacref_pkg::*;

    dacref_state_t  st;
    dacref_state_t  next_st;
    logic           accept;
    logic           wr_acc;
    logic           sel_ctrl;
    logic           sel_level;
    logic [7:0]     next_ctrl;
    logic [7:0]     next_level;
    logic [1:0]     top_field;

    // bus wait-state handshake
    dacref_avs_handshake u_hs (
        .i_mclk        (i_mclk),
        .i_rstn        (i_rstn),
        .i_read        (i_avs_req.read),
        .i_write       (i_avs_req.write),
        .o_waitrequest (o_avs_waitrequest),
        .o_accept      (accept)
    );

    // address decode
    assign sel_ctrl  = (i_avs_req.address == `DACREF_CTRL_OFS);
    assign sel_level = (i_avs_req.address == `DACREF_LEVEL_OFS);
    assign wr_acc    = accept & i_avs_req.write & i_avs_req.byteenable[0];

    // next register values, unimplemented bits forced to zero
    always_comb begin
        next_ctrl  = st.ctrl;
        next_level = st.level;
        if (wr_acc && sel_ctrl) begin
            next_ctrl = i_avs_req.writedata[7:0] & `DACREF_CTRL_MASK;
        end
        if (wr_acc && sel_level) begin
            next_level = i_avs_req.writedata[7:0] & `DACREF_LEVEL_MASK;
        end
        top_field = next_ctrl[`DACREF_TOP_MSB:`DACREF_TOP_LSB];
    end

    // analog controls derived from next values so all move on one edge
    always_comb begin
        next_st       = st;
        next_st.ctrl  = next_ctrl;
        next_st.level = next_level;
        // converter gated by its enable
        next_st.ana.ladder_on = next_ctrl[`DACREF_ON_BIT];
        next_st.ana.tap_sel   = 32'h0000_0001 << next_level[`DACREF_CODE_MSB:0];
        // top source switch, reserved code closes nothing
        next_st.ana.top_sw = 3'h0;
        if (next_ctrl[`DACREF_ON_BIT]) begin
            case (top_field)
                `DACREF_TOP_SUPPLY: next_st.ana.top_sw = 3'h1;
                `DACREF_TOP_EXTPOS: next_st.ana.top_sw = 3'h2;
                `DACREF_TOP_FIXED:  next_st.ana.top_sw = 3'h4;
                default:            next_st.ana.top_sw = 3'h0;
            endcase
        end
        // bottom source switch
        next_st.ana.bottom_sw = 2'h0;
        if (next_ctrl[`DACREF_ON_BIT]) begin
            next_st.ana.bottom_sw = next_ctrl[`DACREF_BOTTOM_BIT] ? 2'h2 : 2'h1;
        end
        // pin routing ignores the enable bit
        next_st.ana.pin_a_sw = next_ctrl[`DACREF_PINA_BIT];
        next_st.ana.pin_b_sw = next_ctrl[`DACREF_PINB_BIT];
        // read data captured during the wait state
        if ((i_avs_req.read) && o_avs_waitrequest) begin
            if (sel_ctrl) begin
                next_st.rdata = {24'h00_0000, st.ctrl};
            end else if (sel_level) begin
                next_st.rdata = {24'h00_0000, st.level};
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end
    end

    // single state register, cleared only by device reset
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st                   <= '0;
            st.ctrl              <= `DACREF_CTRL_RST;
            st.level             <= `DACREF_LEVEL_RST;
            st.ana.tap_sel       <= 32'h0000_0001;
        end else begin
            st <= next_st;
        end
    end

    assign o_analog       = st.ana;
    assign o_avs_readdata = st.rdata;

    // pin a override
    dacref_pin_route u_pin_a (
        .i_route_en   (st.ana.pin_a_sw),
        .i_pin_in     (i_pin_a_in),
        .i_drv_req    (i_pin_a_drv_req),
        .i_pullup_req (i_pin_a_pullup_req),
        .o_drv_en     (o_pin_a_drv_en),
        .o_pullup_en  (o_pin_a_pullup_en),
        .o_inbuf_en   (o_pin_a_inbuf_en),
        .o_read       (o_pin_a_read)
    );

    // pin b override
    dacref_pin_route u_pin_b (
        .i_route_en   (st.ana.pin_b_sw),
        .i_pin_in     (i_pin_b_in),
        .i_drv_req    (i_pin_b_drv_req),
        .i_pullup_req (i_pin_b_pullup_req),
        .o_drv_en     (o_pin_b_drv_en),
        .o_pullup_en  (o_pin_b_pullup_en),
        .o_inbuf_en   (o_pin_b_inbuf_en),
        .o_read       (o_pin_b_read)
    );

    // checks on the register file and analog controls
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    a_ctrl_write: assert property (
        (wr_acc && sel_ctrl) |=> (st.ctrl == ($past(i_avs_req.writedata[7:0]) & 8'hbd))
    ) else $error("control write not stored");

    a_level_write: assert property (
        (wr_acc && sel_level) |=> (o_analog.tap_sel == (32'h0000_0001 << $past(i_avs_req.writedata[4:0])))
    ) else $error("tap does not follow written level");

    a_unimpl_zero: assert property (
        (st.ctrl[6] == 1'b0) && (st.ctrl[1] == 1'b0) && (st.level[7:5] == 3'h0)
    ) else $error("unimplemented bit set");

    a_ladder_off: assert property (
        !st.ctrl[7] |-> (!o_analog.ladder_on && (o_analog.top_sw == 3'h0) && (o_analog.bottom_sw == 2'h0))
    ) else $error("ladder active while disabled");

    a_top_select: assert property (
        (st.ctrl[7] && (st.ctrl[3:2] == 2'h2)) |-> (o_analog.top_sw == 3'h4)
    ) else $error("fixed buffer not selected");

    a_bottom_sel: assert property (
        st.ctrl[7] |-> (o_analog.bottom_sw == (st.ctrl[0] ? 2'h2 : 2'h1))
    ) else $error("bottom source wrong");

    a_pin_route: assert property (
        (o_analog.pin_a_sw == st.ctrl[5]) && (o_analog.pin_b_sw == st.ctrl[4])
    ) else $error("pin routing does not follow route enables");

    a_pin_override: assert property (
        o_analog.pin_a_sw |-> (!o_pin_a_drv_en && !o_pin_a_pullup_en && !o_pin_a_inbuf_en)
    ) else $error("routed pin keeps digital functions");

    a_pin_read: assert property (
        o_analog.pin_b_sw |-> !o_pin_b_read
    ) else $error("routed pin reads non-zero");

    a_ctrl_hold: assert property (
        !(wr_acc && sel_ctrl) |=> $stable(st.ctrl)
    ) else $error("control changed without a write");

    a_one_wait: assert property (
        (i_avs_req.write && o_avs_waitrequest) |=> (!o_avs_waitrequest ##1 (st.ctrl == $past(next_ctrl)))
    ) else $error("write not answered after one wait state");

    // converter enable and level code
    a_ladder_follow: assert property (
        o_analog.ladder_on == st.ctrl[`DACREF_ON_BIT]
    ) else $error("ladder enable does not follow control bit");

    a_ladder_write: assert property (
        (wr_acc && sel_ctrl) |=> (o_analog.ladder_on == $past(i_avs_req.writedata[7]))
    ) else $error("ladder enable not taken from write");

    a_tap_follow: assert property (
        o_analog.tap_sel == (32'h0000_0001 << st.level[`DACREF_CODE_MSB:0])
    ) else $error("tap select does not match level code");

    a_tap_onehot: assert property (
        $onehot(o_analog.tap_sel)
    ) else $error("not exactly one ladder tap closed");

    a_level_store: assert property (
        (wr_acc && sel_level) |=> (st.level == ($past(i_avs_req.writedata[7:0]) & `DACREF_LEVEL_MASK))
    ) else $error("level write not stored");

    a_level_hold: assert property (
        !(wr_acc && sel_level) |=> $stable(st.level)
    ) else $error("level changed without a write");

    // source switches
    a_top_supply: assert property (
        (st.ctrl[7] && (st.ctrl[3:2] == `DACREF_TOP_SUPPLY)) |-> (o_analog.top_sw == 3'h1)
    ) else $error("supply not selected as ladder top");

    a_top_extpos: assert property (
        (st.ctrl[7] && (st.ctrl[3:2] == `DACREF_TOP_EXTPOS)) |-> (o_analog.top_sw == 3'h2)
    ) else $error("external positive not selected as ladder top");

    a_top_rsvd: assert property (
        (st.ctrl[3:2] == `DACREF_TOP_RSVD) |-> (o_analog.top_sw == 3'h0)
    ) else $error("reserved top code closed a switch");

    a_top_onehot: assert property (
        $onehot0(o_analog.top_sw)
    ) else $error("two top switches closed");

    a_bottom_onehot: assert property (
        st.ctrl[7] |-> $onehot(o_analog.bottom_sw)
    ) else $error("not exactly one bottom switch closed");

    // pin overrides on both pins
    a_pin_b_override: assert property (
        o_analog.pin_b_sw |-> (!o_pin_b_drv_en && !o_pin_b_pullup_en && !o_pin_b_inbuf_en)
    ) else $error("routed pin b keeps digital functions");

    a_pin_a_read: assert property (
        o_analog.pin_a_sw |-> !o_pin_a_read
    ) else $error("routed pin a reads non-zero");

    a_pin_a_free: assert property (
        !o_analog.pin_a_sw |-> ((o_pin_a_drv_en == i_pin_a_drv_req) && (o_pin_a_pullup_en == i_pin_a_pullup_req)
                                && o_pin_a_inbuf_en && (o_pin_a_read == i_pin_a_in))
    ) else $error("released pin a lost its digital functions");

    a_pin_b_free: assert property (
        !o_analog.pin_b_sw |-> ((o_pin_b_drv_en == i_pin_b_drv_req) && (o_pin_b_pullup_en == i_pin_b_pullup_req)
                                && o_pin_b_inbuf_en && (o_pin_b_read == i_pin_b_in))
    ) else $error("released pin b lost its digital functions");

    a_off_pins_kept: assert property (
        !o_analog.ladder_on |-> ((o_pin_a_inbuf_en == !st.ctrl[5]) && (o_pin_b_inbuf_en == !st.ctrl[4]))
    ) else $error("disabled converter released a routed pin");

    // register bus answers
    a_read_ctrl: assert property (
        (i_avs_req.read && !o_avs_waitrequest && sel_ctrl) |-> (o_avs_readdata == {24'h00_0000, st.ctrl})
    ) else $error("control read answer wrong");

    a_read_level: assert property (
        (i_avs_req.read && !o_avs_waitrequest && sel_level) |-> (o_avs_readdata == {24'h00_0000, st.level})
    ) else $error("level read answer wrong");

    a_read_unmapped: assert property (
        (i_avs_req.read && !o_avs_waitrequest && !sel_ctrl && !sel_level) |-> (o_avs_readdata == 32'h0000_0000)
    ) else $error("unmapped read not zero");

    a_unmapped_write: assert property (
        (accept && i_avs_req.write && !sel_ctrl && !sel_level) |=> ($stable(st.ctrl) && $stable(st.level))
    ) else $error("unmapped write changed a register");

    a_lane_ignored: assert property (
        (accept && i_avs_req.write && !i_avs_req.byteenable[0]) |=> ($stable(st.ctrl) && $stable(st.level))
    ) else $error("write without byte lane changed a register");

    a_wait_first: assert property (
        $rose(i_avs_req.read || i_avs_req.write) |-> o_avs_waitrequest
    ) else $error("request answered without a wait state");

    a_idle_no_wait: assert property (
        !(i_avs_req.read || i_avs_req.write) |-> !o_avs_waitrequest
    ) else $error("wait requested while idle");

    a_read_one_wait: assert property (
        (i_avs_req.read && o_avs_waitrequest) |=> !o_avs_waitrequest
    ) else $error("read not answered after one wait state");

    a_analog_quiet: assert property (
        !wr_acc |=> $stable(o_analog)
    ) else $error("analog controls moved without a write");

    c_route_off: cover property (o_analog.pin_a_sw && !o_analog.ladder_on);
    c_level_max: cover property (o_analog.tap_sel[31]);
    c_read_ctrl: cover property (accept && i_avs_req.read && sel_ctrl);
    c_ext_refs: cover property (o_analog.top_sw[1] && o_analog.bottom_sw[1]);
    c_pin_b_only: cover property (o_analog.pin_b_sw && !o_analog.pin_a_sw);
endmodule // dacref_top
`default_nettype wire

/* File: dv/dacref_ladder_model.sv */
`default_nettype none
module dacref_ladder_model (
    input  wire logic i_mclk,
    input  wire logic i_pin_a_sw,
    input  wire logic i_pin_b_sw,
    input  wire logic i_lvl,
    output logic      o_pin_a,
    output logic      o_pin_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wobble = 1'b0;
    // a routed pin carries an analog level, its digital sense is not stable
    always @(posedge i_mclk) begin
        wobble <= ~wobble;
    end
    // unrouted pins show the level the bench puts on them
    assign o_pin_a = i_pin_a_sw ? wobble : i_lvl;
    assign o_pin_b = i_pin_b_sw ? wobble : i_lvl;
endmodule // dacref_ladder_model
`default_nettype wire

/* File: dv/dac_reference_control_tb.sv */
`include "dacref_defines.svh"
`default_nettype none
module dac_reference_control_tb import dacref_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic            i_mclk = 1'b0;
    logic            i_rstn = 1'b0;
    dacref_avs_req_t req    = '0;
    logic            wreq;
    logic [31:0]     rdata;
    logic [31:0]     rd;
    dacref_analog_t  ana;
    logic            lvl    = 1'b1;
    logic            pa_in;
    logic            pb_in;
    wire [3:0]       pa_o;
    wire [3:0]       pb_o;
    int              err_total   = 0;
    int              checks_done = 0;
    int              cyc         = 0;

    dacref_top i_dut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_req(req), .o_avs_waitrequest(wreq),
        .o_avs_readdata(rdata), .o_analog(ana),
        .i_pin_a_in(pa_in), .i_pin_a_drv_req(lvl), .i_pin_a_pullup_req(lvl),
        .o_pin_a_drv_en(pa_o[3]), .o_pin_a_pullup_en(pa_o[2]), .o_pin_a_inbuf_en(pa_o[1]), .o_pin_a_read(pa_o[0]),
        .i_pin_b_in(pb_in), .i_pin_b_drv_req(lvl), .i_pin_b_pullup_req(lvl),
        .o_pin_b_drv_en(pb_o[3]), .o_pin_b_pullup_en(pb_o[2]), .o_pin_b_inbuf_en(pb_o[1]), .o_pin_b_read(pb_o[0])
    );

    dacref_ladder_model i_far (
        .i_mclk(i_mclk), .i_pin_a_sw(ana.pin_a_sw), .i_pin_b_sw(ana.pin_b_sw),
        .i_lvl(lvl), .o_pin_a(pa_in), .o_pin_b(pb_in)
    );

    // 10 MHz clock
    always #50 i_mclk = ~i_mclk;

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one avalon access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic be);
        int n;
        n = 0;
        @(posedge i_mclk);
        req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: {3'h0, be}};
        // waitrequest and read data sampled at the same rising edge
        do begin
            @(posedge i_mclk);
            n++;
        end while (wreq !== 1'b0);
        rd = rdata;
        req <= '0;
        chk("wait_states", n - 1, `DACREF_WAIT_CYCLES);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b1);
        chk("readdata", rd, {56'h0, e});
    endtask

    // analog controls plus the pin override outputs that follow them
    task automatic achk(input logic on, input int code, input logic [2:0] top, input logic [1:0] bot,
                        input logic pa, input logic pb);
        dacref_analog_t e;
        e = '{ladder_on: on, tap_sel: 32'h1 << code, top_sw: top, bottom_sw: bot, pin_a_sw: pa, pin_b_sw: pb};
        @(negedge i_mclk);
        chk("analog", ana, e);
        chk("pin_a", pa_o, pa ? 4'h0 : {lvl, lvl, 1'b1, lvl});
        chk("pin_b", pb_o, pb ? 4'h0 : {lvl, lvl, 1'b1, lvl});
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'b1;
        achk(0, 0, 3'h0, 2'h0, 0, 0);
        rchk(`DACREF_CTRL_OFS, 8'h00);
        rchk(`DACREF_LEVEL_OFS, 8'h00);
        wr(`DACREF_CTRL_OFS, 8'hff);
        achk(1, 0, 3'h0, 2'h2, 1, 1);
        rchk(`DACREF_CTRL_OFS, 8'hbd);
        for (int t = 0; t < 3; t++) begin
            wr(`DACREF_CTRL_OFS, 8'h80 | 8'(t << 2));
            achk(1, 0, 3'h1 << t, 2'h1, 0, 0);
        end
        for (int c = 0; c < 32; c++) begin
            wr(`DACREF_LEVEL_OFS, 8'he0 | 8'(c));
            rchk(`DACREF_LEVEL_OFS, 8'(c));
            achk(1, c, 3'h4, 2'h1, 0, 0);
        end
        // port logic requests and pin level dropped from here on
        lvl <= 1'b0;
        wr(`DACREF_CTRL_OFS, 8'h20);
        achk(0, 31, 3'h0, 2'h0, 1, 0);
        wr(`DACREF_CTRL_OFS, 8'h10);
        achk(0, 31, 3'h0, 2'h0, 0, 1);
        // refused writes: unmapped place and disabled byte lane
        wr(4'h8, 8'hff);
        bus(1'b1, `DACREF_CTRL_OFS, 8'hff, 1'b0);
        rchk(`DACREF_CTRL_OFS, 8'h10);
        rchk(4'h8, 8'h00);
        // reset in mid-run with converter on, both pins routed and level at 31
        wr(`DACREF_CTRL_OFS, 8'hb5);
        @(posedge i_mclk);
        i_rstn <= 1'b0;
        achk(0, 0, 3'h0, 2'h0, 0, 0);
        @(posedge i_mclk);
        i_rstn <= 1'b1;
        rchk(`DACREF_CTRL_OFS, 8'h00);
        rchk(`DACREF_LEVEL_OFS, 8'h00);
        end_of_test();
    end
endmodule // dac_reference_control_tb
`default_nettype wire
